// File: core/sarc_pkg.sv
// constants and carrier types for the successive-approximation sequencer
package sarc_pkg;
   // converter clock ticks are enables derived from core_clk
   localparam int unsigned CORE_HZ = 50000000;
   localparam int unsigned CONV_HZ = 2000000;
   localparam logic [4:0] CONV_DIV = 5'(CORE_HZ / CONV_HZ);
   localparam logic [10:0] CAL_CLKS = 11'h574;
   localparam logic [10:0] CAL_OFFSET_CLKS = 11'h01a;
   localparam logic [10:0] NULL_CLKS = 11'h01a;
   localparam logic [10:0] SAMPLE_CLKS = 11'h007;
   localparam logic [3:0] SIGN_BIT = 4'hc;
   localparam int unsigned RES_W = 13;
   localparam logic [RES_W-1:0] RES_RST = 13'h0000;
   // test mode lanes: bits 2, 3, 5 and 6 of the result bus
   localparam logic [RES_W-1:0] TEST_LANES = 13'h006c;

   typedef enum logic [2:0] {
      SARC_IDLE = 3'b000,
      SARC_NULL = 3'b001,
      SARC_SAMP = 3'b011,
      SARC_CONV = 3'b010,
      SARC_CAL = 3'b110
   } sarc_state_t;

   // host-side control strobes, all active low
   typedef struct packed {
      logic select_n;
      logic read_strobe_n;
      logic launch_strobe_n;
      logic selfadjust_request_n;
      logic offset_null_request_n;
   } sarc_ctl_t;

   typedef struct packed {
      sarc_state_t st;
      logic [4:0] div;
      logic [10:0] cnt;
      logic [3:0] bitn;
      logic [RES_W-1:0] sar;
      logic [RES_W-1:0] res;
      logic ready_n;
      logic launch_d;
      logic cal_d;
      logic [11:0] offset_corr;
      logic [11:0] ladder_corr;
   } sarc_regs_t;
endpackage

// File: core/sarc_top.sv
// sequencer for a self-calibrating 12-bit plus sign sar converter
`timescale 1ns/1ns
module sarc_top
   import sarc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // host control strobes
   input wire sarc_ctl_t ctl,
   // comparator decision from the analog front end
   input wire logic cmp_greater,
   // status toward the host
   output logic conversion_busy_n,
   output logic result_ready_n,
   // result bus as two signals, data and output enable
   output logic [RES_W-1:0] result_bus_o,
   output logic [RES_W-1:0] result_bus_oe,
   // analog front end control
   output logic [RES_W-1:0] dac_code,
   output logic sample_en,
   output logic null_en,
   output logic cal_en
);
   sarc_regs_t r, n;
   logic tick;
   logic sel;
   logic rd;
   logic launch_rise;
   logic cal_fall;
   logic test_mode;

   // strobes decoded
   // select gates the read, launch and test-mode strobes, not the calibration request
   assign sel = ~ctl.select_n;
   assign rd = sel & ~ctl.read_strobe_n;
   assign launch_rise = sel & r.launch_d & ~ctl.launch_strobe_n ? 1'b0 :
                        sel & ~r.launch_d & ctl.launch_strobe_n;
   assign cal_fall = r.cal_d & ~ctl.selfadjust_request_n;
   assign test_mode = sel & ~ctl.selfadjust_request_n & ctl.read_strobe_n;
   assign tick = (r.div == 5'(CONV_DIV - 5'h01));

   // next-state logic
   always_comb begin
      n = r;
      n.launch_d = ctl.launch_strobe_n;
      n.cal_d = ctl.selfadjust_request_n;
      n.div = tick ? 5'h00 : 5'(r.div + 5'h01);
      if (rd) begin
         n.ready_n = 1'b1;
      end
      case (r.st)
         SARC_IDLE, SARC_NULL, SARC_SAMP, SARC_CONV: begin
            if (r.st == SARC_NULL && tick) begin
               n.cnt = 11'(r.cnt + 11'h001);
               if (r.cnt == 11'(NULL_CLKS - 11'h001)) begin
                  n.st = SARC_SAMP;
                  n.cnt = 11'h000;
                  n.offset_corr = {11'h000, cmp_greater};
               end
            end
            if (r.st == SARC_SAMP && tick) begin
               n.cnt = 11'(r.cnt + 11'h001);
               if (r.cnt == 11'(SAMPLE_CLKS - 11'h001)) begin
                  n.st = SARC_CONV;
                  n.bitn = SIGN_BIT;
                  n.sar = RES_RST;
               end
            end
            if (r.st == SARC_CONV && tick) begin
               if (r.bitn == SIGN_BIT) begin
                  n.sar[SIGN_BIT] = ~cmp_greater;
                  n.sar[11] = 1'b1;
               end else begin
                  n.sar[r.bitn] = cmp_greater;
                  if (r.bitn != 4'h0) begin
                     n.sar[r.bitn - 4'h1] = 1'b1;
                  end
               end
               n.bitn = 4'(r.bitn - 4'h1);
               if (r.bitn == 4'h0) begin
                  n.res = {r.sar[RES_W-1:1], cmp_greater};
                  n.st = SARC_IDLE;
                  n.ready_n = 1'b0;
               end
            end
            if (launch_rise) begin
               n.st = ctl.offset_null_request_n ? SARC_SAMP : SARC_NULL;
               n.cnt = 11'h000;
               n.div = 5'h00;
               n.ready_n = 1'b1;
            end
            if (cal_fall) begin
               n.st = SARC_CAL;
               n.cnt = 11'h000;
               n.div = 5'h00;
               n.ready_n = 1'b1;
            end
         end
         SARC_CAL: begin
            if (tick) begin
               n.cnt = 11'(r.cnt + 11'h001);
               if (r.cnt < CAL_OFFSET_CLKS) begin
                  n.offset_corr = {r.offset_corr[10:0], cmp_greater};
               end else begin
                  n.ladder_corr = {r.ladder_corr[10:0], cmp_greater};
               end
               if (r.cnt == 11'(CAL_CLKS - 11'h001)) begin
                  n.st = SARC_IDLE;
                  n.cnt = 11'h000;
               end
            end
         end
         default: begin
            n.st = SARC_IDLE;
         end
      endcase
   end

   // state register; calibration after reset
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '{st: SARC_CAL, div: 5'h00, cnt: 11'h000, bitn: 4'h0, sar: RES_RST,
                res: RES_RST, ready_n: 1'b1, launch_d: 1'b1, cal_d: 1'b1,
                offset_corr: 12'h000, ladder_corr: 12'h000};
      end else begin
         r <= n;
      end
   end

   // outputs
   // busy low during offset null, conversion and calibration, high while sampling
   assign conversion_busy_n = ~(r.st == SARC_CONV || r.st == SARC_CAL || r.st == SARC_NULL);
   assign result_ready_n = r.ready_n;
   assign result_bus_o = r.res;
   assign result_bus_oe = rd ? {RES_W{1'b1}} : (test_mode ? TEST_LANES : RES_RST);
   assign dac_code = r.sar;
   assign sample_en = (r.st == SARC_SAMP);
   assign null_en = (r.st == SARC_NULL);
   assign cal_en = (r.st == SARC_CAL);
endmodule

// File: dv/sarc_asserts.sv
// port assertions for the sar sequencer
`timescale 1ns/1ns
module sarc_chk
   import sarc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // strobes, status and result
   input wire sarc_ctl_t ctl,
   input wire logic conversion_busy_n,
   input wire logic result_ready_n,
   input wire logic [RES_W-1:0] result_bus_o,
   input wire logic [RES_W-1:0] result_bus_oe,
   input wire logic null_en,
   input wire logic cal_en
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   wire rd = !ctl.select_n && !ctl.read_strobe_n;
   a_read_drive: assert property (rd |-> &result_bus_oe) else $error("read idle");
   a_read_clear: assert property (rd |=> result_ready_n) else $error("read kept");
   a_desel_off: assert property (ctl.select_n |-> result_bus_oe == '0) else $error("desel");
   a_test_lanes:
   assert property (!ctl.select_n && !ctl.selfadjust_request_n && !rd |-> result_bus_oe == TEST_LANES) else $error("tm");
   a_cal_busy: assert property (cal_en |-> !conversion_busy_n) else $error("cal");
   a_null_busy: assert property (null_en |-> !conversion_busy_n) else $error("null");
   a_done_flags: assert property ($fell(result_ready_n) |-> conversion_busy_n && !cal_en) else $error("done");
   a_latch_hold: assert property ($changed(result_bus_o) |-> $fell(result_ready_n)) else $error("latch");
endmodule
bind sarc_top sarc_chk sarc_chk_i (.core_clk(core_clk), .nrst(nrst), .ctl(ctl), .conversion_busy_n(conversion_busy_n),
   .result_ready_n(result_ready_n), .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe), .null_en(null_en),
   .cal_en(cal_en));

// File: dv/sarc_fe.sv
// comparator model for a held input
`timescale 1ns/1ns
module sarc_fe
   import sarc_pkg::*;
(
   input wire logic [RES_W-1:0] vin,
   output logic cmp_greater
);
   // a full-scale input beats every trial, a most negative one loses every trial
   assign cmp_greater = ~vin[RES_W-1];
endmodule

// File: dv/tb_sarc_top.sv
// self-checking bench for the sar sequencer
`timescale 1ns/1ns
module tb_sarc_top
   import sarc_pkg::*;
   ;
   logic core_clk = 1'b0, nrst = 1'b0, cmp, busy_n, rdy_n, samp;
   sarc_ctl_t ctl = 5'h1f;
   logic [RES_W-1:0] vin = 13'h0fff, res, oe, dac;
   int err_total = 0, n_compared = 0, n;
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
   sarc_top sarc_top_i (.core_clk(core_clk), .nrst(nrst), .ctl(ctl), .cmp_greater(cmp), .conversion_busy_n(busy_n),
      .result_ready_n(rdy_n), .result_bus_o(res), .result_bus_oe(oe), .dac_code(dac), .sample_en(samp), .null_en(),
      .cal_en());
   sarc_fe sarc_fe_i (.vin(vin), .cmp_greater(cmp));
   // 20 ns core clock
   // converter ticks come from this clock divided to 2 MHz
   initial forever #10 core_clk = ~core_clk;
   task automatic stop_test();
      if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tick(int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic wait_lv(bit rdy, logic lv, int lim);
      for (n = 0; (rdy ? rdy_n : busy_n) !== lv && n <= lim; n++) tick(1);
      `CHK("in_time", 1'b1, n <= lim)
      if (n > lim) stop_test();
   endtask
   task automatic launch();
      {ctl.select_n, ctl.launch_strobe_n} = 2'b00;
      tick(2);
      ctl.launch_strobe_n = 1'b1;
      tick(1);
      ctl.select_n = 1'b1;
   endtask
   // one conversion, busy and sample level at start, time until ready, then a read
   task automatic t_convert(logic az_n, logic [RES_W-1:0] v, int tks);
      vin = v;
      // offset null level held steady through the conversion
      ctl.offset_null_request_n = az_n;
      launch();
      `CHK("busy_st", az_n, busy_n)
      `CHK("samp_st", az_n, samp)
      wait_lv(1, 1'b0, 2000);
      `CHK("conv_len", 1'b1, n > (tks - 1) * CONV_DIV && n < (tks + 1) * CONV_DIV)
      `CHK("dac_end", v, dac)
      ctl[4:3] = 2'b00;
      tick(1);
      `CHK("rd_res", v, res)
      `CHK("rd_oe", 13'h1fff, oe)
      `CHK("rd_rdy", 1'b1, rdy_n)
      ctl[4:3] = 2'b11;
      tick(1);
   endtask
   // calibration request; test mode and a launch meanwhile
   task automatic t_cal();
      // pulse selfadjust with select, read and launch high; offset null is still low from the last conversion
      ctl.selfadjust_request_n = 1'b0;
      tick(2);
      ctl.select_n = 1'b0;
      tick(1);
      `CHK("tm_oe", TEST_LANES, oe)
      // selfadjust back high before any launch
      ctl = 5'h1f;
      tick(1);
      launch();
      `CHK("cal_hold", 1'b0, busy_n)
      wait_lv(0, 1'b1, 36000);
      `CHK("cal_len", 1'b1, n > 1396 * CONV_DIV - 40 && n < 1396 * CONV_DIV + 30)
   endtask
   // reset, power-up calibration, then the scenarios
   initial begin
      tick(5);
      nrst = 1'b1;
      wait_lv(0, 1'b1, 36000);
      `CHK("pwr_cal", 1'b1, n > 1396 * CONV_DIV - 30 && n < 1396 * CONV_DIV + 30)
      t_convert(1'b1, 13'h0fff, 20);
      t_convert(1'b0, 13'h1000, 46);
      t_cal();
      stop_test();
   end
endmodule
